// *** design/srp_packetizer.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "srp_defines.svh"

module srp_packetizer #(
   parameter int MS_CYCLES = `SRP_MS_NS / `SRP_CLK_PERIOD_NS
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic serialInputPin,
   output logic serialOutputPin,
   output logic ctsPinN,
   input wire logic [2:0] interfaceRateSelect,
   input wire logic [7:0] packetizationTimeout,
   input wire logic [15:0] guardInterval,
   input wire logic [7:0] escapeCharacter,
   input wire logic ctsPinConfig,
   input wire logic apiMode,
   output logic cmdModeReq,
   output logic apiFrameOk,
   output logic apiFrameBad,
   output logic apiCmdFrame,
   output logic [7:0] txByte,
   output logic txByteValid,
   output logic txByteLast,
   input wire logic txByteReady,
   input wire logic radioBusy,
   input wire logic txStatusValid,
   input wire logic txStatusOk,
   input wire logic [7:0] rxByte,
   input wire logic rxValid,
   input wire logic rxLast,
   output logic rxReady,
   input wire logic [15:0] rxSrcAddr,
   input wire logic [7:0] rxRssi,
   input wire logic [7:0] rxLen,
   input wire logic eventValid,
   input wire logic [7:0] eventCode
);
   import srp_pkg::*;

   localparam int DI_LW = $clog2(`SRP_DI_DEPTH) + 2;
   localparam int RX_LW = $clog2(`SRP_RX_DEPTH) + 2;
   localparam logic [DI_LW-1:0] CTS_OFF_LVL = DI_LW'(`SRP_DI_DEPTH - `SRP_CTS_OFF_FREE);
   localparam logic [DI_LW-1:0] CTS_ON_LVL = DI_LW'(`SRP_DI_DEPTH - `SRP_CTS_ON_FREE);

   srp_state_t q, d;
   logic [15:0] divTop;
   logic tick16, bitTick, byteDone;
   logic diReady, diOutValid, diPop;
   logic [7:0] diOutData;
   logic [DI_LW-1:0] diLevel;
   logic [7:0] avail;
   logic rxInValid, rxInReady, rxOutValid, rxPop;
   logic [7:0] rxOutData;
   logic [RX_LW-1:0] rxLevel;
   logic [7:0] outByte;
   logic outValid, outTake;

   // Sixteen-times oversample divisor per rate code
   always_comb begin
      unique case (q.rate)
         3'h0: divTop = 16'(`SRP_CLK_HZ / (`SRP_OVERSAMPLE * `SRP_BAUD_0) - 1);
         3'h1: divTop = 16'(`SRP_CLK_HZ / (`SRP_OVERSAMPLE * `SRP_BAUD_1) - 1);
         3'h2: divTop = 16'(`SRP_CLK_HZ / (`SRP_OVERSAMPLE * `SRP_BAUD_2) - 1);
         3'h3: divTop = 16'(`SRP_CLK_HZ / (`SRP_OVERSAMPLE * `SRP_BAUD_3) - 1);
         3'h4: divTop = 16'(`SRP_CLK_HZ / (`SRP_OVERSAMPLE * `SRP_BAUD_4) - 1);
         3'h5: divTop = 16'(`SRP_CLK_HZ / (`SRP_OVERSAMPLE * `SRP_BAUD_5) - 1);
         3'h6: divTop = 16'(`SRP_CLK_HZ / (`SRP_OVERSAMPLE * `SRP_BAUD_6) - 1);
         3'h7: divTop = 16'(`SRP_CLK_HZ / (`SRP_OVERSAMPLE * `SRP_BAUD_7) - 1);
      endcase
   end

   // Rate enables and buffer glue
   assign tick16 = (q.divCnt == divTop);
   assign bitTick = tick16 && (q.bitPhase == 4'hf);
   assign byteDone = tick16 && (q.urx == URX_STOP) && (q.rxTick == 4'hf) && serialInputPin;
   assign avail = 8'(diLevel) - 8'(q.escCnt);
   assign diPop = (q.rel == REL_DROP) || ((q.rel == REL_SEND) && txByteReady);
   assign txByteValid = (q.rel == REL_SEND) && diOutValid;
   assign txByte = diOutData;
   assign txByteLast = txByteValid && (q.relCnt == 8'h01);
   assign rxInValid = rxValid && !(apiMode && q.rxFirst && q.metaHeld);
   assign rxReady = rxInReady && !(apiMode && q.rxFirst && q.metaHeld);
   assign outTake = outValid && !q.utxBusy;
   assign rxPop = outTake && (!apiMode || (q.aout == OUT_PAY));
   assign serialOutputPin = q.utxBusy ? q.utxShift[0] : 1'b1;
   assign ctsPinN = ctsPinConfig ? q.cts : 1'b0;
   assign cmdModeReq = q.cmdMode;
   assign apiFrameOk = q.apiOk;
   assign apiFrameBad = q.apiBad;
   assign apiCmdFrame = q.apiCmd;

   // Byte offered to the serial transmitter
   always_comb begin
      outByte = rxOutData;
      outValid = 1'b0;
      if (!apiMode) begin
         outValid = rxOutValid;
      end else begin
         unique case (q.aout)
            OUT_IDLE: outValid = 1'b0;
            OUT_HDR: begin
               outByte = q.hdr[q.hdrIdx];
               outValid = 1'b1;
            end
            OUT_PAY: outValid = rxOutValid;
            OUT_SUM: begin
               outByte = `SRP_API_SUM_OK - q.oSum;
               outValid = 1'b1;
            end
         endcase
      end
   end

   always_comb begin
      d = q;
      d.rate = interfaceRateSelect;
      d.cmdMode = 1'b0;
      d.apiOk = 1'b0;
      d.apiBad = 1'b0;
      d.divCnt = tick16 ? 16'h0 : q.divCnt + 16'h1;
      if (tick16) begin
         d.bitPhase = q.bitPhase + 4'h1;
      end

      // Receiver: start, eight data bits, one stop bit
      if (tick16) begin
         d.rxTick = q.rxTick + 4'h1;
         unique case (q.urx)
            URX_IDLE: begin
               d.rxTick = 4'h0;
               if (!serialInputPin) begin
                  d.urx = URX_START;
               end
            end
            URX_START: begin
               if (q.rxTick == `SRP_MID_TICK) begin
                  d.rxTick = 4'h0;
                  d.rxBit = 3'h0;
                  d.urx = serialInputPin ? URX_IDLE : URX_DATA;
               end
            end
            URX_DATA: begin
               if (q.rxTick == 4'hf) begin
                  d.rxShift = {serialInputPin, q.rxShift[7:1]};
                  d.rxBit = q.rxBit + 3'h1;
                  if (q.rxBit == 3'h7) begin
                     d.urx = URX_STOP;
                  end
               end
            end
            URX_STOP: begin
               if (q.rxTick == 4'hf) begin
                  d.urx = URX_IDLE;
               end
            end
         endcase
      end

      // Idle time in character times and silence in milliseconds
      d.msCnt = (q.msCnt == 17'(MS_CYCLES - 1)) ? 17'h0 : q.msCnt + 17'h1;
      if (q.msCnt == 17'(MS_CYCLES - 1) && q.silenceMs != 16'hffff) begin
         d.silenceMs = q.silenceMs + 16'h1;
      end
      if (bitTick && q.urx == URX_IDLE) begin
         d.idleBits = (q.idleBits == `SRP_CHAR_BITS - 4'h1) ? 4'h0 : q.idleBits + 4'h1;
         if (q.idleBits == `SRP_CHAR_BITS - 4'h1 && q.idleChars != 8'hff) begin
            d.idleChars = q.idleChars + 8'h1;
         end
      end

      if (byteDone) begin
         d.idleBits = 4'h0;
         d.idleChars = 8'h0;
         d.silenceMs = 16'h0;
         // The first escape character counts only after guard silence
         if (!apiMode && q.rxShift == escapeCharacter &&
             ((q.escCnt == 2'h0 && q.silenceMs >= guardInterval) ||
              (q.escCnt != 2'h0 && q.escCnt != `SRP_ESC_LEN))) begin
            d.escCnt = q.escCnt + 2'h1;
         end else begin
            d.escCnt = 2'h0;
         end
      end else if (q.escCnt == `SRP_ESC_LEN && q.silenceMs >= guardInterval && !q.escFlush) begin
         // Trailing guard silence confirms the sequence
         d.escCnt = 2'h0;
         d.escFlush = 1'b1;
         d.escKeep = 8'(diLevel) - 8'(`SRP_ESC_LEN);
         d.cmdMode = 1'b1;
      end

      // Input frame parser: length, identifier, checksum
      if (apiMode && byteDone) begin
         unique case (q.apin)
            API_DELIM: d.apin = (q.rxShift == `SRP_API_DELIM) ? API_LENH : API_DELIM;
            API_LENH: begin
               d.apiLen[15:8] = q.rxShift;
               d.apin = API_LENL;
            end
            API_LENL: begin
               d.apiLen[7:0] = q.rxShift;
               d.apiSum = 8'h0;
               d.apiFirst = 1'b1;
               d.apin = ({q.apiLen[15:8], q.rxShift} == 16'h0) ? API_DELIM : API_BODY;
            end
            API_BODY: begin
               d.apiSum = q.apiSum + q.rxShift;
               d.apiFirst = 1'b0;
               if (q.apiFirst) begin
                  d.apiId = q.rxShift;
               end
               d.apiLen = q.apiLen - 16'h1;
               if (q.apiLen == 16'h1) begin
                  d.apin = API_SUM;
               end
            end
            API_SUM: begin
               d.apin = API_DELIM;
               d.apiFlush = 1'b1;
               if (8'(q.apiSum + q.rxShift) == `SRP_API_SUM_OK &&
                   (q.apiId == `SRP_API_TX64 || q.apiId == `SRP_API_TX16 ||
                    q.apiId == `SRP_API_CMD || q.apiId == `SRP_API_CMDQ)) begin
                  d.apiOk = 1'b1;
                  d.apiCmd = (q.apiId == `SRP_API_CMD || q.apiId == `SRP_API_CMDQ);
               end else begin
                  d.apiBad = 1'b1;
               end
            end
            default: d.apin = API_DELIM;
         endcase
      end

      // Packet release toward the radio
      unique case (q.rel)
         REL_IDLE: begin
            // Start no release while the radio is busy; a packet already being sent continues
            if (!radioBusy) begin
               if (q.escFlush) begin
                  // Send what preceded the sequence, then drop it
                  d.escFlush = 1'b0;
                  d.relCnt = q.escKeep;
                  d.dropCnt = `SRP_ESC_LEN;
                  d.rel = (q.escKeep == 8'h0) ? REL_DROP : REL_SEND;
               end else if (avail >= `SRP_MAX_PAYLOAD) begin
                  d.relCnt = `SRP_MAX_PAYLOAD;
                  d.dropCnt = 2'h0;
                  d.rel = REL_SEND;
               end else if (avail != 8'h0 && q.escCnt == 2'h0 &&
                            (apiMode ? q.apiFlush : (q.idleChars >= packetizationTimeout))) begin
                  // Frame end in framed mode, else idle timeout where zero timeout flushes at once
                  d.apiFlush = 1'b0;
                  d.relCnt = avail;
                  d.dropCnt = 2'h0;
                  d.rel = REL_SEND;
               end
            end
         end
         REL_SEND: begin
            if (diOutValid && txByteReady) begin
               d.relCnt = q.relCnt - 8'h1;
               if (q.relCnt == 8'h1) begin
                  d.rel = (q.dropCnt == 2'h0) ? REL_IDLE : REL_DROP;
               end
            end
         end
         REL_DROP: begin
            if (diOutValid) begin
               d.dropCnt = q.dropCnt - 2'h1;
               if (q.dropCnt == 2'h1) begin
                  d.rel = REL_IDLE;
               end
            end
         end
         default: d.rel = REL_IDLE;
      endcase

      if (diLevel >= CTS_OFF_LVL) begin
         d.cts = 1'b1;
      end else if (diLevel <= CTS_ON_LVL) begin
         d.cts = 1'b0;
      end

      if (outTake) begin
         d.utxBusy = 1'b1;
         d.utxShift = {1'b1, outByte, 1'b0};
         d.utxTick = 4'h0;
         d.utxBits = 4'h0;
      end else if (q.utxBusy && tick16) begin
         d.utxTick = q.utxTick + 4'h1;
         if (q.utxTick == 4'hf) begin
            d.utxShift = {1'b1, q.utxShift[9:1]};
            d.utxBits = q.utxBits + 4'h1;
            d.utxBusy = (q.utxBits != `SRP_CHAR_BITS - 4'h1);
         end
      end

      // In framed mode, capture packet details with its first byte
      if (rxInValid && rxInReady) begin
         d.rxFirst = rxLast;
         if (q.rxFirst && apiMode) begin
            d.metaHeld = 1'b1;
            d.srcAddr = rxSrcAddr;
            d.rssi = rxRssi;
            d.pLen = rxLen;
         end
      end

      // Output frame generator, status before events before data
      // Only framed mode latches reports; one already pending is kept across a mode change
      if (txStatusValid && apiMode) begin
         d.statPend = 1'b1;
         d.statOk = txStatusOk;
      end
      if (eventValid && apiMode) begin
         d.evtPend = 1'b1;
         d.evtCode = eventCode;
      end
      if (apiMode) begin
         unique case (q.aout)
            OUT_IDLE: begin
               d.hdrIdx = 3'h0;
               d.oSum = 8'h0;
               d.payLeft = 8'h0;
               if (q.statPend) begin
                  d.statPend = txStatusValid;
                  d.hdr = {16'h0, 7'h0, !q.statOk, `SRP_API_FRAME_ID, `SRP_API_TXSTAT, 16'h0300, `SRP_API_DELIM};
                  d.hdrLast = 3'h5;
                  d.aout = OUT_HDR;
               end else if (q.evtPend) begin
                  d.evtPend = eventValid;
                  d.hdr = {24'h0, q.evtCode, `SRP_API_EVENT, 16'h0200, `SRP_API_DELIM};
                  d.hdrLast = 3'h4;
                  d.aout = OUT_HDR;
               end else if (q.metaHeld && rxOutValid) begin
                  d.hdr = {8'h00, q.rssi, q.srcAddr[7:0], q.srcAddr[15:8], `SRP_API_RX16,
                           8'(q.pLen + 8'h5), 8'h00, `SRP_API_DELIM};
                  d.hdrLast = 3'h7;
                  d.payLeft = q.pLen;
                  d.aout = OUT_HDR;
               end
            end
            OUT_HDR: begin
               if (outTake) begin
                  d.hdrIdx = q.hdrIdx + 3'h1;
                  if (q.hdrIdx >= 3'h3) begin
                     d.oSum = q.oSum + outByte;
                  end
                  if (q.hdrIdx == q.hdrLast) begin
                     d.aout = (q.payLeft != 8'h0) ? OUT_PAY : OUT_SUM;
                  end
               end
            end
            OUT_PAY: begin
               if (outTake) begin
                  d.oSum = q.oSum + outByte;
                  d.payLeft = q.payLeft - 8'h1;
                  if (q.payLeft == 8'h1) begin
                     d.metaHeld = 1'b0;
                     d.aout = OUT_SUM;
                  end
               end
            end
            OUT_SUM: begin
               if (outTake) begin
                  d.aout = OUT_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         q <= '0;
         q.rate <= `SRP_RATE_RESET;
         q.rxFirst <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // Serial input buffer; a byte with no room is lost
   srp_fifo #(.WIDTH(8), .DEPTH(`SRP_DI_DEPTH)) diBuffer (
      .clk(clk),
      .rst(rst),
      .inData(q.rxShift),
      .inValid(byteDone),
      .inReady(diReady),
      .outData(diOutData),
      .outValid(diOutValid),
      .outReady(diPop),
      .level(diLevel)
   );

   // Radio receive buffer, drained by the serial transmitter
   srp_fifo #(.WIDTH(8), .DEPTH(`SRP_RX_DEPTH)) rxBuffer (
      .clk(clk),
      .rst(rst),
      .inData(rxByte),
      .inValid(rxInValid),
      .inReady(rxInReady),
      .outData(rxOutData),
      .outValid(rxOutValid),
      .outReady(rxPop),
      .level(rxLevel)
   );

endmodule : srp_packetizer

`default_nettype wire

// *** include/srp_defines.svh ***
`ifndef SRP_DEFINES_SVH
`define SRP_DEFINES_SVH

// System clock
`define SRP_CLK_HZ 100000000
`define SRP_CLK_PERIOD_NS 10
`define SRP_MS_NS 1000000

// Serial line
`define SRP_RATE_RESET 3'h3
`define SRP_BAUD_0 1200
`define SRP_BAUD_1 2400
`define SRP_BAUD_2 4800
`define SRP_BAUD_3 9600
`define SRP_BAUD_4 19200
`define SRP_BAUD_5 38400
`define SRP_BAUD_6 57600
`define SRP_BAUD_7 115200
`define SRP_OVERSAMPLE 16
`define SRP_MID_TICK 4'h7
`define SRP_CHAR_BITS 4'ha

// Buffers and packets
`define SRP_DI_DEPTH 128
`define SRP_RX_DEPTH 4
`define SRP_MAX_PAYLOAD 8'h64
`define SRP_CTS_OFF_FREE 17
`define SRP_CTS_ON_FREE 34
`define SRP_ESC_LEN 2'h3

// Frame bytes
`define SRP_API_DELIM 8'h7e
`define SRP_API_RX16 8'h81
`define SRP_API_TXSTAT 8'h89
`define SRP_API_EVENT 8'h8a
`define SRP_API_TX64 8'h00
`define SRP_API_TX16 8'h01
`define SRP_API_CMD 8'h08
`define SRP_API_CMDQ 8'h09
`define SRP_API_FRAME_ID 8'h01
`define SRP_API_SUM_OK 8'hff

`endif

// *** include/srp_pkg.sv ***
package srp_pkg;

   typedef enum logic [1:0] {URX_IDLE = 2'b00, URX_START = 2'b01, URX_DATA = 2'b10, URX_STOP = 2'b11} srp_urx_t;
   typedef enum logic [1:0] {REL_IDLE = 2'b00, REL_SEND = 2'b01, REL_DROP = 2'b10} srp_rel_t;
   typedef enum logic [2:0] {
      API_DELIM = 3'b000, API_LENH = 3'b001, API_LENL = 3'b010, API_BODY = 3'b011, API_SUM = 3'b100
   } srp_apin_t;
   typedef enum logic [1:0] {OUT_IDLE = 2'b00, OUT_HDR = 2'b01, OUT_PAY = 2'b10, OUT_SUM = 2'b11} srp_aout_t;

   typedef struct packed {
      logic [2:0] rate;
      logic [15:0] divCnt;
      logic [3:0] bitPhase;
      srp_urx_t urx;
      logic [3:0] rxTick;
      logic [2:0] rxBit;
      logic [7:0] rxShift;
      logic [3:0] idleBits;
      logic [7:0] idleChars;
      logic [16:0] msCnt;
      logic [15:0] silenceMs;
      logic [1:0] escCnt;
      logic escFlush;
      logic [7:0] escKeep;
      logic apiFlush;
      srp_rel_t rel;
      logic [7:0] relCnt;
      logic [1:0] dropCnt;
      logic cmdMode;
      logic cts;
      logic utxBusy;
      logic [3:0] utxTick;
      logic [3:0] utxBits;
      logic [9:0] utxShift;
      srp_apin_t apin;
      logic [15:0] apiLen;
      logic [7:0] apiSum;
      logic [7:0] apiId;
      logic apiFirst;
      logic apiOk;
      logic apiBad;
      logic apiCmd;
      srp_aout_t aout;
      logic [7:0][7:0] hdr;
      logic [2:0] hdrIdx;
      logic [2:0] hdrLast;
      logic [7:0] payLeft;
      logic [7:0] oSum;
      logic rxFirst;
      logic metaHeld;
      logic [15:0] srcAddr;
      logic [7:0] rssi;
      logic [7:0] pLen;
      logic statPend;
      logic statOk;
      logic evtPend;
      logic [7:0] evtCode;
   } srp_state_t;

endpackage : srp_pkg

// *** design/srp_fifo.sv ***
`timescale 1ns/1ns
`default_nettype none

// Circular buffer with a registered output word; level counts both
module srp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] inData,
   input wire logic inValid,
   output logic inReady,
   output logic [WIDTH-1:0] outData,
   output logic outValid,
   input wire logic outReady,
   output logic [$clog2(DEPTH)+1:0] level
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
      logic oValid;
      logic [WIDTH-1:0] oData;
   } srp_fifo_state_t;

   srp_fifo_state_t q, d;
   logic push, pop, load;

   // Handshakes and level
   assign inReady = (q.cnt != (AW+1)'(DEPTH));
   assign outValid = q.oValid;
   assign outData = q.oData;
   assign level = (AW+2)'(q.cnt) + (AW+2)'(q.oValid);

   // Next state: write, refill output register, pop
   always_comb begin
      d = q;
      push = inValid && inReady;
      pop = q.oValid && outReady;
      load = (!q.oValid || pop) && (q.cnt != '0);
      if (pop) begin
         d.oValid = 1'b0;
      end
      if (load) begin
         d.oData = q.mem[q.rp];
         d.oValid = 1'b1;
         d.rp = q.rp + 1'b1;
      end
      if (push) begin
         d.mem[q.wp] = inData;
         d.wp = q.wp + 1'b1;
      end
      d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(load);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

endmodule : srp_fifo

`default_nettype wire

// *** test/srp_packetizer_sva.sv ***
`timescale 1ns/1ns
`default_nettype none

// Port-level checks of the packetizer
module srp_packetizer_sva #(
   parameter int MS_CYCLES = 10
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic serialOutputPin,
   input wire logic ctsPinN,
   input wire logic ctsPinConfig,
   input wire logic apiMode,
   input wire logic cmdModeReq,
   input wire logic apiFrameOk,
   input wire logic apiFrameBad,
   input wire logic [7:0] txByte,
   input wire logic txByteValid,
   input wire logic txByteLast,
   input wire logic txByteReady,
   input wire logic radioBusy,
   input wire logic rxReady
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_resetIdle; $fell(rst) |-> serialOutputPin && !ctsPinN && rxReady && !txByteValid; endproperty
   a_resetIdle: assert property (p_resetIdle) else $error("outputs not idle after reset");
   property p_startBit; $fell(serialOutputPin) |-> !serialOutputPin [*8]; endproperty
   a_startBit: assert property (p_startBit) else $error("start bit too short");
   property p_stallHold; txByteValid && !txByteReady |=> txByteValid && $stable(txByte) && $stable(txByteLast);
   endproperty
   a_stallHold: assert property (p_stallHold) else $error("packet byte dropped while stalled");
   property p_lastValid; txByteLast |-> txByteValid; endproperty
   a_lastValid: assert property (p_lastValid) else $error("last marker without valid");
   property p_busyHold; (radioBusy && !txByteValid) [*3] |=> !txByteValid; endproperty
   a_busyHold: assert property (p_busyHold) else $error("packet started while radio busy");
   property p_ctsOff; !ctsPinConfig |-> !ctsPinN; endproperty
   a_ctsOff: assert property (p_ctsOff) else $error("clear-to-send held off while disabled");
   property p_apiPulse; apiFrameOk |-> !apiFrameBad ##1 !apiFrameOk; endproperty
   a_apiPulse: assert property (p_apiPulse) else $error("frame verdict pulse malformed");
   property p_escPulse; cmdModeReq |-> !$past(apiMode) ##1 !cmdModeReq; endproperty
   a_escPulse: assert property (p_escPulse) else $error("escape pulse malformed");

   c_escape: cover property (cmdModeReq);
   c_packetEnd: cover property (txByteValid && txByteReady && txByteLast);
   c_radioRefused: cover property (!rxReady);
endmodule : srp_packetizer_sva

bind srp_packetizer srp_packetizer_sva #(.MS_CYCLES(MS_CYCLES)) chk_u (.*);

`default_nettype wire

// *** test/srp_host_model.sv ***
`timescale 1ns/1ns
`default_nettype none

// Host serial port: sender and receiver of 8N1 characters
module srp_host_model #(
   parameter int BIT_CYC = 868
) (
   input wire logic clk,
   input wire logic ctsPinN,
   input wire logic fromDevice,
   output logic toDevice
);
   logic [7:0] rxQ[$];
   logic [7:0] sh;

   initial toDevice = 1'b1;

   task automatic sendChar(input logic [7:0] b);
      logic [9:0] frm;
      frm = {1'b1, b, 1'b0};
      while (ctsPinN !== 1'b0) @(negedge clk);
      for (int i = 0; i < 10; i++) begin
         toDevice = frm[i];
         repeat (BIT_CYC) @(negedge clk);
      end
   endtask : sendChar

   // Receiver samples each bit mid-cell
   always @(negedge fromDevice) begin
      repeat (BIT_CYC / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT_CYC) @(posedge clk);
         sh[i] = fromDevice;
      end
      rxQ.push_back(sh);
      repeat (BIT_CYC) @(posedge clk);
   end
endmodule : srp_host_model

`default_nettype wire

// *** test/tb_srp_packetizer.sv ***
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, exp, act) begin checks++; if ((act) !== (exp)) begin badCount++; \
   $display("MISMATCH %s expected %0h seen %0h", nm, exp, act); end end

module tb_srp_packetizer;
   localparam int BIT_CYC = 868;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic serialInputPin, serialOutputPin, ctsPinN, ctsPinConfig, apiMode, cmdModeReq, apiFrameOk, apiFrameBad;
   logic apiCmdFrame, txByteValid, txByteLast, txByteReady, radioBusy, txStatusValid, txStatusOk;
   logic rxValid, rxLast, rxReady, eventValid;
   logic [2:0] interfaceRateSelect;
   logic [7:0] packetizationTimeout, escapeCharacter, txByte, rxByte, rxRssi, rxLen, eventCode, got;
   logic [15:0] guardInterval, rxSrcAddr;
   logic gotLast;
   int badCount = 0;
   int checks = 0;
   int cycles = 0;
   int cmdSeen = 0;
   int refused = 0;

   srp_packetizer #(.MS_CYCLES(10)) dut_u (.*);
   srp_host_model #(.BIT_CYC(BIT_CYC)) host_u (.clk(clk), .ctsPinN(ctsPinN), .fromDevice(serialOutputPin),
      .toDevice(serialInputPin));

   // Clock, escape pulse count and watchdog
   always #5 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cmdModeReq === 1'b1) cmdSeen++;
      if (cycles == 90000) begin
         badCount++;
         finishTest();
      end
   end

   task automatic finishTest();
      $display("checks %0d mismatches %0d", checks, badCount);
      if (badCount == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : finishTest

   // Offer one radio byte, held until taken
   task automatic radioPush(input logic [7:0] b, input logic last);
      rxByte = b;
      rxLast = last;
      rxValid = 1'b1;
      while (rxReady !== 1'b1) begin
         refused++;
         @(negedge clk);
      end
      @(posedge clk);
      @(negedge clk);
   endtask : radioPush

   // Accept one packet byte after a short stall, then report status if it was the last
   task automatic takeByte();
      int n;
      n = 0;
      while (txByteValid !== 1'b1 && n < 20000) begin
         n++;
         @(negedge clk);
      end
      repeat (3) @(negedge clk);
      got = txByte;
      gotLast = txByteLast;
      txByteReady = 1'b1;
      @(posedge clk);
      @(negedge clk);
      txByteReady = 1'b0;
      txStatusOk = 1'b1;
      txStatusValid = gotLast;
      @(negedge clk);
      txStatusValid = 1'b0;
   endtask : takeByte

   initial begin
      {ctsPinConfig, apiMode, txByteReady, radioBusy, txStatusValid, txStatusOk, rxValid, rxLast, eventValid} = '0;
      interfaceRateSelect = 3'h7;
      {packetizationTimeout, rxByte, eventCode} = '0;
      escapeCharacter = 8'h2b;
      guardInterval = 16'h0002;
      rxSrcAddr = 16'h1234;
      rxRssi = 8'h28;
      rxLen = 8'h06;
      repeat (6) @(negedge clk);
      rst = 1'b0;
      repeat (2) @(negedge clk);
      ctsPinConfig = 1'b1;
      fork
         begin
            for (int i = 0; i < 7; i++) radioPush(8'ha0 + 8'(i), i == 6);
            rxValid = 1'b0;
            while (host_u.rxQ.size() < 7) @(negedge clk);
            for (int i = 0; i < 7; i++) `CHK("serialOut", 8'ha0 + 8'(i), host_u.rxQ[i])
            `CHK("rxRefused", 1'b1, refused > 0)
         end
         begin
            host_u.sendChar(8'h5a);
            takeByte();
            `CHK("txByte", 8'h5a, got)
            `CHK("txByteLast", 1'b1, gotLast)
            packetizationTimeout = 8'h01;
            radioBusy = 1'b1;
            host_u.sendChar(8'h3c);
            repeat (2 * 10 * BIT_CYC) @(negedge clk);
            `CHK("txByteValid", 1'b0, txByteValid)
            radioBusy = 1'b0;
            takeByte();
            `CHK("txByte", 8'h3c, got)
            packetizationTimeout = 8'hff;
            host_u.sendChar(8'h11);
            repeat (100) @(negedge clk);
            repeat (3) host_u.sendChar(8'h2b);
            takeByte();
            `CHK("txByte", 8'h11, got)
            `CHK("txByteLast", 1'b1, gotLast)
            repeat (50) @(negedge clk);
            `CHK("txByteValid", 1'b0, txByteValid)
            `CHK("cmdModeReq", 1, cmdSeen)
         end
      join
      finishTest();
   end
endmodule : tb_srp_packetizer

`default_nettype wire
